// File: logic/ptw_defines.svh
// Offsets, reset values and timing figures for the trigger waveform timing block.
// Assumes a 16-bit host register port with byte addresses and a 10 MHz clock.
`ifndef PTW_DEFINES_SVH
`define PTW_DEFINES_SVH

// ==========================================================================
// Register byte offsets on the host register port
// ==========================================================================
`define PTW_ADDR_W              11
`define PTW_OFF_PULSE_WIDTH     11'h22A
`define PTW_OFF_CYCLE_WIDTH_LO  11'h22C
`define PTW_OFF_CYCLE_WIDTH_HI  11'h22E
`define PTW_OFF_COUNT           11'h230
`define PTW_OFF_PATTERN         11'h232
`define PTW_OFF_ITER_TIME_LO    11'h234
`define PTW_OFF_ITER_TIME_HI    11'h236

// ==========================================================================
// Reset values and timing
// ==========================================================================
`define PTW_REG_RESET           16'h0000
`define PTW_CLK_PERIOD_NS       32'h0000_0064
`define PTW_PW_STEP_SHIFT       3

`endif

// File: logic/ptw_pkg.sv
// Types shared by the trigger waveform timing block.
// Assumes the constants header is compiled alongside it.
package ptw_pkg;

  // ========================================================================
  // Output pattern encodings of the 3-bit pattern field
  // ========================================================================
  typedef enum logic [2:0] {
    falling_edge_mode      = 3'h0,
    rising_edge_mode       = 3'h1,
    negative_pulse_mode    = 3'h2,
    positive_pulse_mode    = 3'h3,
    negative_periodic_mode = 3'h4,
    positive_periodic_mode = 3'h5,
    pattern_shift_mode     = 3'h6,
    reserved_mode          = 3'h7
  } ptw_mode_t;

  // ========================================================================
  // Sequencer states
  // ========================================================================
  typedef enum logic [1:0] {
    PTW_IDLE,
    PTW_RUN,
    PTW_WAIT,
    PTW_HOLD
  } ptw_state_t;

  // ========================================================================
  // Software-visible settings carried as one bundle
  // ========================================================================
  typedef struct packed {
    logic [15:0] pulse_width_reg;
    logic [15:0] cycle_width_low_reg;
    logic [15:0] cycle_width_high_reg;
    logic [15:0] count_reg;
    logic [15:0] pattern_reg;
    logic [15:0] iteration_time_low_reg;
    logic [15:0] iteration_time_high_reg;
  } ptw_cfg_t;

endpackage : ptw_pkg

// File: logic/ptw_trigger_timing.sv
// Waveform timing and sequencing of one time-synchronised trigger output unit.
// Assumes start is a one-cycle pulse from on-chip time compare logic on the same clock.
//
// Summary of operation
// - Pulse or active phase lasts width times 8 ns.
// - Tail cascade pattern: repeat count is width plus one.
// - Cycle width is high:low words in ns.
// - Pattern mode uses cycle width per bit.
// - Periodic modes emit count cycles; zero endless.
// - Pattern mode emits count bits; zero endless.
// - Pattern register supplies levels in pattern mode.
// - Tail cascade periodic: iterations are pattern plus one.
// - Cascade adds iteration time to target time.
// - Pattern shifts LSB first and loops around.
// - Three-bit field selects seven output patterns.
// - Iteration time high word from separate register.
`timescale 1ns/1ps
`include "ptw_defines.svh"

module ptw_trigger_timing (
  input  wire logic                        clock,        // 10 MHz system clock.
  input  wire logic                        resetn,       // Asynchronous reset, active low.
  input  wire logic                        reg_wr,       // Register write strobe.
  input  wire logic                        reg_rd,       // Register read strobe.
  input  wire logic [`PTW_ADDR_W-1:0]      reg_addr,     // Register byte address.
  input  wire logic [15:0]                 reg_wdata,    // Register write data.
  output logic      [15:0]                 reg_rdata,    // Read data, one cycle after strobe.
  input  wire ptw_pkg::ptw_mode_t          out_mode,     // Output pattern select.
  input  wire logic                        trig_en,      // Unit enable level.
  input  wire logic                        cascade_en,   // Cascade mode level.
  input  wire logic                        tail_unit,    // A tail unit exists in the cascade.
  input  wire logic                        start,        // Target time reached pulse.
  input  wire logic [31:0]                 target_time,  // Current trigger target time.
  output logic                             trig_out,     // Trigger output level.
  output logic                             busy,         // Run or waiting for next iteration.
  output logic                             done,         // Sequence exhausted, holding.
  output logic      [31:0]                 next_target   // Next cascade trigger time.
);
  import ptw_pkg::*;

  // ========================================================================
  // Helper functions
  // ========================================================================
  // A phase is over once the elapsed time reaches its limit; a zero limit
  // ends the phase at once so that zero settings never hang the unit.
  function automatic logic phase_over(input logic [31:0] elapsed, input logic [31:0] limit);
    phase_over = (limit == 32'h0000_0000) || (elapsed >= limit);
  endfunction : phase_over

  // ========================================================================
  // Register storage and host access
  // ========================================================================
  ptw_cfg_t         cfg_q;        // Software settings.
  logic [15:0]      rdata_q;      // Registered read data.
  logic [15:0]      rdata_d;      // Read mux result.

  wire wr_pw   = reg_wr && (reg_addr == `PTW_OFF_PULSE_WIDTH);
  wire wr_cwl  = reg_wr && (reg_addr == `PTW_OFF_CYCLE_WIDTH_LO);
  wire wr_cwh  = reg_wr && (reg_addr == `PTW_OFF_CYCLE_WIDTH_HI);
  wire wr_cnt  = reg_wr && (reg_addr == `PTW_OFF_COUNT);
  wire wr_pat  = reg_wr && (reg_addr == `PTW_OFF_PATTERN);
  wire wr_itl  = reg_wr && (reg_addr == `PTW_OFF_ITER_TIME_LO);
  wire wr_ith  = reg_wr && (reg_addr == `PTW_OFF_ITER_TIME_HI);

  // Read mux; unmapped addresses return zero rather than stale data.
  always_comb begin
    case (reg_addr)
      `PTW_OFF_PULSE_WIDTH:    rdata_d = cfg_q.pulse_width_reg;
      `PTW_OFF_CYCLE_WIDTH_LO: rdata_d = cfg_q.cycle_width_low_reg;
      `PTW_OFF_CYCLE_WIDTH_HI: rdata_d = cfg_q.cycle_width_high_reg;
      `PTW_OFF_COUNT:          rdata_d = cfg_q.count_reg;
      `PTW_OFF_PATTERN:        rdata_d = cfg_q.pattern_reg;
      `PTW_OFF_ITER_TIME_LO:   rdata_d = cfg_q.iteration_time_low_reg;
      `PTW_OFF_ITER_TIME_HI:   rdata_d = cfg_q.iteration_time_high_reg;
      default:                 rdata_d = 16'h0000;
    endcase
  end

  // Settings update; each word is written whole, no byte lanes.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= {7{`PTW_REG_RESET}};
    end else begin
      if (wr_pw)  cfg_q.pulse_width_reg         <= reg_wdata;
      if (wr_cwl) cfg_q.cycle_width_low_reg     <= reg_wdata;
      if (wr_cwh) cfg_q.cycle_width_high_reg    <= reg_wdata;
      if (wr_cnt) cfg_q.count_reg               <= reg_wdata;
      if (wr_pat) cfg_q.pattern_reg             <= reg_wdata;
      if (wr_itl) cfg_q.iteration_time_low_reg  <= reg_wdata;
      if (wr_ith) cfg_q.iteration_time_high_reg <= reg_wdata;
    end
  end

  // Read data is captured on the read strobe and held until the next one.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rdata_q <= 16'h0000;
    else if (reg_rd) rdata_q <= rdata_d;
  end

  // ========================================================================
  // Derived timing values and mode decode
  // ========================================================================
  // Pulse width in ns: eight ns per step.
  wire [31:0] pw_ns = {13'h0000, cfg_q.pulse_width_reg, 3'h0};
  // Cycle or bit width assembled from its two words, in ns.
  wire [31:0] cycle_ns = {cfg_q.cycle_width_high_reg, cfg_q.cycle_width_low_reg};
  // Iteration cycle time assembled from its two words, in ns.
  wire [31:0] iter_ns = {cfg_q.iteration_time_high_reg, cfg_q.iteration_time_low_reg};

  wire is_edge  = (out_mode == falling_edge_mode) || (out_mode == rising_edge_mode);
  wire is_pulse = (out_mode == negative_pulse_mode) || (out_mode == positive_pulse_mode);
  wire is_pat   = (out_mode == pattern_shift_mode);
  wire is_rsvd  = (out_mode == reserved_mode);
  // Odd codes are the positive flavours; their resting level is low.
  wire act_lvl  = out_mode[0];
  wire idle_lvl = is_pat ? 1'b0 : ~out_mode[0];

  // ========================================================================
  // Sequencer
  // ========================================================================
  ptw_state_t  state_q, state_d;   // Sequencer state.
  logic [31:0] elapsed_q, elapsed_d; // Time spent in the current cycle or bit.
  logic [15:0] unit_q, unit_d;     // Cycles or bits emitted in this run.
  logic [15:0] rep_q, rep_d;       // Repetitions finished.
  logic [3:0]  bit_q, bit_d;       // Pattern bit position.
  logic        hold_q, hold_d;     // Level held after the sequence ends.
  logic        out_q, out_d;       // Trigger output.
  logic [31:0] next_q;             // Next cascade trigger time.

  wire [31:0] elapsed_nx = elapsed_q + `PTW_CLK_PERIOD_NS;
  wire        unit_end   = phase_over(elapsed_nx, cycle_ns);
  wire        pulse_end  = phase_over(elapsed_nx, pw_ns);
  // A zero count never matches, so the run continues without end.
  wire        last_unit  = (cfg_q.count_reg != 16'h0000) &&
                           ((unit_q + 16'h0001) == cfg_q.count_reg);
  wire        run_end    = is_pulse ? pulse_end : (unit_end && last_unit);
  // Tail cascade repeat limit: pattern mode uses the width word, else the pattern word.
  wire [15:0] rep_limit  = is_pat ? cfg_q.pulse_width_reg : cfg_q.pattern_reg;
  wire        endless    = cascade_en && !tail_unit;
  wire        more_reps  = cascade_en && (endless || (rep_q != rep_limit));
  wire        begin_ok   = trig_en && start && (state_q != PTW_RUN);

  // Next-state logic and the level the output takes one edge later.
  always_comb begin
    state_d   = state_q;
    elapsed_d = elapsed_q;
    unit_d    = unit_q;
    rep_d     = rep_q;
    bit_d     = bit_q;
    hold_d    = hold_q;
    out_d     = idle_lvl;
    case (state_q)
      PTW_RUN: begin
        if (is_pat) begin
          out_d = cfg_q.pattern_reg[bit_q];
        end else begin
          out_d = (elapsed_q < pw_ns) ? act_lvl : idle_lvl;
        end
        // A pulse times against its width only; restarting at each cycle end would
        // let a short cycle setting stretch the pulse without limit.
        elapsed_d = (unit_end && !is_pulse) ? 32'h0000_0000 : elapsed_nx;
        if (unit_end) begin
          unit_d = unit_q + 16'h0001;
          bit_d  = bit_q + 4'h1;
        end
        if (run_end) begin
          // Another iteration waits for the next target time; otherwise hold.
          if (more_reps) begin
            state_d = PTW_WAIT;
            rep_d   = rep_q + 16'h0001;
          end else begin
            state_d = PTW_HOLD;
            hold_d  = idle_lvl;
          end
        end
      end
      PTW_HOLD: out_d = hold_q;
      default:  out_d = idle_lvl;
    endcase
    if (begin_ok) begin
      elapsed_d = 32'h0000_0000;
      unit_d    = 16'h0000;
      if (state_q != PTW_WAIT) begin
        rep_d = 16'h0000;
        bit_d = 4'h0;
      end
      if (is_edge || is_rsvd) begin
        // Edges switch once and stay; the unused code just stays idle.
        state_d = PTW_HOLD;
        hold_d  = is_edge ? act_lvl : idle_lvl;
        out_d   = hold_d;
      end else begin
        state_d = PTW_RUN;
      end
    end
    if (!trig_en) begin
      state_d = PTW_IDLE;
      out_d   = idle_lvl;
    end
  end

  // State registers; the always_comb above carries all decisions.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q   <= PTW_IDLE;
      elapsed_q <= 32'h0000_0000;
      unit_q    <= 16'h0000;
      rep_q     <= 16'h0000;
      bit_q     <= 4'h0;
      hold_q    <= 1'b0;
      out_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      elapsed_q <= elapsed_d;
      unit_q    <= unit_d;
      rep_q     <= rep_d;
      bit_q     <= bit_d;
      hold_q    <= hold_d;
      out_q     <= out_d;
    end
  end

  // ========================================================================
  // Cascade next trigger time
  // ========================================================================
  // Captured at each accepted start in cascade mode; the total waveform must fit inside the
  // iteration time, which this block trusts software to ensure.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) next_q <= 32'h0000_0000;
    else if (begin_ok && cascade_en) next_q <= target_time + iter_ns;
  end

  // ========================================================================
  // Status flags, registered so every output comes from a flip-flop
  // ========================================================================
  logic busy_q; // Running or between iterations.
  logic done_q; // Holding after the sequence.

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= (state_d == PTW_RUN) || (state_d == PTW_WAIT);
      done_q <= (state_d == PTW_HOLD);
    end
  end

  assign reg_rdata   = rdata_q;
  assign trig_out    = out_q;
  assign busy        = busy_q;
  assign done        = done_q;
  assign next_target = next_q;

endmodule : ptw_trigger_timing

// File: tb/ptw_trigger_timing_properties.sv
// Concurrent checks on the ports of the trigger waveform timing block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`include "ptw_defines.svh"
module ptw_trigger_timing_properties (
  input wire logic                   clock,       // System clock.
  input wire logic                   resetn,      // Reset, active low.
  input wire logic                   reg_wr,      // Write strobe.
  input wire logic                   reg_rd,      // Read strobe.
  input wire logic [`PTW_ADDR_W-1:0] reg_addr,    // Byte address.
  input wire logic [15:0]            reg_wdata,   // Write data.
  input wire logic [15:0]            reg_rdata,   // Read data.
  input wire ptw_pkg::ptw_mode_t     out_mode,    // Pattern select.
  input wire logic                   trig_en,     // Enable level.
  input wire logic                   start,       // Start pulse.
  input wire logic                   trig_out,    // Output level.
  input wire logic                   busy,        // Running or waiting.
  input wire logic                   done,        // Holding.
  input wire logic [31:0]            next_target  // Next cascade time.
);
  import ptw_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ======================================================================
  // Helpers
  // ======================================================================
  // A start that the unit must take; starts seen while waiting are left out.
  wire take   = start && trig_en && !busy;
  wire mapped = reg_addr inside {`PTW_OFF_PULSE_WIDTH, `PTW_OFF_CYCLE_WIDTH_LO,
    `PTW_OFF_CYCLE_WIDTH_HI, `PTW_OFF_COUNT, `PTW_OFF_PATTERN,
    `PTW_OFF_ITER_TIME_LO, `PTW_OFF_ITER_TIME_HI};
  sequence s_wr;
    reg_wr && mapped;
  endsequence
  sequence s_rd;
    reg_rd && !reg_wr && reg_addr == $past(reg_addr);
  endsequence
  // ======================================================================
  // Assertions
  // ======================================================================
  AST_RD_AFTER_WR: assert property (s_wr ##1 s_rd |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Read after write returned stale data.");
  AST_UNMAPPED: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000)
    else $error("Unmapped read was not zero.");
  AST_RDATA_STANDS: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("Read data moved without a read.");
  AST_EXCL: assert property (!(busy && done))
    else $error("Busy and done together.");
  AST_OFF: assert property (!trig_en |=> !busy && !done)
    else $error("Disabled unit not idle.");
  // The first held cycle may still show the last active level, so check from the second.
  AST_HOLD: assert property (done && $past(done) && trig_en && !start && $stable(out_mode)
    |=> done && $stable(trig_out))
    else $error("Held level changed.");
  AST_TAKE: assert property (take |-> ##2 (busy || done))
    else $error("Start not taken.");
  AST_PULSE: assert property (take && out_mode == positive_pulse_mode |-> ##2 trig_out)
    else $error("Positive pulse missing.");
  AST_RISE: assert property (take && out_mode == rising_edge_mode |-> ##2 (trig_out && done))
    else $error("Rising edge missing.");
  AST_FALL: assert property (take && out_mode == falling_edge_mode |-> ##2 (!trig_out && done))
    else $error("Falling edge missing.");
  AST_TGT: assert property (!start |=> $stable(next_target))
    else $error("Next target moved without a start.");
endmodule : ptw_trigger_timing_properties

// File: tb/ptw_trigger_timing_test.sv
// Self-checking random bench for the trigger waveform timing block.
// Assumes the header, package, design and checker are compiled first.
`timescale 1ns/1ps
`include "ptw_defines.svh"
module ptw_trigger_timing_test;
  import ptw_pkg::*;
  // ======================================================================
  // Signals and expectation state
  // ======================================================================
  logic                   clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, start = 0;
  logic                   trig_en = 0, cascade_en = 0, tail_unit = 0;
  logic [`PTW_ADDR_W-1:0] reg_addr = '0;
  logic [15:0]            reg_wdata = '0, pw, cnt, pat, v;
  logic [31:0]            target_time = '0, cyc, tt, it;
  ptw_mode_t              out_mode = positive_pulse_mode;
  wire  [15:0]            reg_rdata;
  wire                    trig_out, busy, done;
  wire  [31:0]            next_target;
  int                     err_total = 0, checks_done = 0;
  logic [`PTW_ADDR_W-1:0] offs [7] = '{`PTW_OFF_PULSE_WIDTH, `PTW_OFF_CYCLE_WIDTH_LO,
    `PTW_OFF_CYCLE_WIDTH_HI, `PTW_OFF_COUNT, `PTW_OFF_PATTERN, `PTW_OFF_ITER_TIME_LO,
    `PTW_OFF_ITER_TIME_HI};
  always #50 clock = ~clock;
  ptw_trigger_timing dut (.clock, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .out_mode, .trig_en, .cascade_en, .tail_unit, .start, .target_time,
    .trig_out, .busy, .done, .next_target);
  // ======================================================================
  // Tasks and expectation
  // ======================================================================
  // Inputs always move 1 ns after the edge, so no race with the design.
  task automatic tick();
    @(posedge clock);
    #1;
  endtask : tick
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Strobes stay up after a transfer so that back-to-back calls never toggle one
  // within a single time step; idle_unit and run drop them.
  task automatic wr(logic [`PTW_ADDR_W-1:0] a, logic [15:0] d);
    reg_rd = 0;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick();
  endtask : wr
  task automatic rd(logic [`PTW_ADDR_W-1:0] a, output logic [15:0] d);
    reg_wr = 0;
    reg_addr = a;
    reg_rd = 1;
    tick();
    d = reg_rdata;
  endtask : rd
  task automatic prog();
    wr(`PTW_OFF_PULSE_WIDTH, pw);
    wr(`PTW_OFF_CYCLE_WIDTH_LO, cyc[15:0]);
    wr(`PTW_OFF_CYCLE_WIDTH_HI, cyc[31:16]);
    wr(`PTW_OFF_COUNT, cnt);
    wr(`PTW_OFF_PATTERN, pat);
  endtask : prog
  // A start while disabled must be ignored and the unit left idle.
  task automatic idle_unit();
    reg_wr = 0;
    reg_rd = 0;
    trig_en = 0;
    start = 1;
    tick();
    start = 0;
    trig_en = 1;
    chk("idle busy", busy, 0);
    chk("idle done", done, 0);
    tick();
  endtask : idle_unit
  // Level expected k clocks after the first active clock; even codes below six are active low.
  function automatic logic expv(int m, int k);
    int c, h;
    logic a;
    c = (int'(cyc) + 99) / 100;
    h = (int'(pw) * 8 + 99) / 100;
    if (c == 0) c = 1;
    if (h == 0) h = 1;
    case (m)
      0, 1: a = 1;
      2, 3: a = (k < h);
      4, 5: a = (cnt == 0 || k < cnt * c) && ((k % c) * 100 < pw * 8);
      6: a = (cnt == 0 || k < cnt * c) && pat[(k / c) % 16];
      default: a = 0;
    endcase
    return (m % 2 == 0 && m < 6) ? !a : a;
  endfunction : expv
  // The first active level is registered one edge after the start is taken.
  task automatic run(ptw_mode_t m);
    reg_wr = 0;
    reg_rd = 0;
    out_mode = m;
    start = 1;
    tick();
    start = 0;
    for (int k = 0; k < 48; k++) begin
      tick();
      chk("trig_out", trig_out, expv(int'(m), k));
    end
    $display("test mode %0d done", m);
  endtask : run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // ======================================================================
  // Main sequence
  // ======================================================================
  initial begin
    logic [15:0] d;
    logic e;
    void'($urandom(32'h68FA7C21));
    repeat (5) @(posedge clock);
    #1 resetn = 1;
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk("reset value", d, 16'h0000);
      v = $urandom;
      wr(offs[i], v);
      rd(offs[i], d);
      chk("readback", d, v);
    end
    wr(11'h238, 16'hFFFF);
    rd(11'h238, d);
    chk("unmapped", d, 16'h0000);
    rd(offs[6], d);
    chk("no alias", d, v);
    $display("test registers done");
    // Every code twice; the second pass runs the periodic and pattern codes endless.
    for (int r = 0; r < 16; r++) begin
      pw = $urandom_range(40, 1);
      cyc = $urandom_range(250, 1);
      cnt = $urandom_range(15, 0);
      pat = $urandom;
      if (r == 6) begin
        cyc = 100;
        cnt = 20;
      end
      if (r > 11 && r < 15) cnt = 0;
      prog();
      idle_unit();
      run(ptw_mode_t'(r % 8));
      e = (r % 8 < 4 || r % 8 == 7 || cnt != 0);
      chk("done", done, e);
      chk("busy", busy, !e);
    end
    // Tail cascade: periodic repeats pattern value plus one, pattern uses width plus one.
    cascade_en = 1;
    tail_unit = 1;
    for (int i = 0; i < 2; i++) begin
      pw = i ? 16'h0000 : 16'h0014;
      pat = i ? 16'hA5C3 : 16'h0001;
      cnt = 16'h0002;
      cyc = 32'h0000_0096;
      prog();
      idle_unit();
      tt = $urandom;
      it = $urandom | 32'h0001_0000;
      target_time = tt;
      wr(`PTW_OFF_ITER_TIME_LO, it[15:0]);
      wr(`PTW_OFF_ITER_TIME_HI, it[31:16]);
      for (int j = 0; j <= 1 - i; j++) begin
        run(i ? pattern_shift_mode : positive_periodic_mode);
        chk("cascade done", done, j == 1 - i);
        chk("next target", next_target, tt + it);
      end
    end
    stop_test();
  end
  // Guards against a hang; running out counts as a mismatch.
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    stop_test();
  end
endmodule : ptw_trigger_timing_test
bind ptw_trigger_timing ptw_trigger_timing_properties u_props (.clock, .resetn, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .out_mode, .trig_en, .start, .trig_out,
  .busy, .done, .next_target);
